//--- logic/wff_top.sv
`timescale 1ns/1ps
`default_nettype none
module wff_top
  import wff_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Receive byte stream
  input wire wff_rx_beat_s rx_beat_in,
  // Events
  output logic wake_frame_out,
  output logic irq_out
);

  // Configuration storage
  logic [31:0] mask_reg [NUM_FILTERS]; // Byte masks
  logic [31:0] crc_pair_reg [2]; // Low pair and high pair CRCs
  logic [31:0] offsets_reg; // Start offsets, one lane each
  logic [31:0] last_reg; // Last-byte values, one lane each
  logic [CMD_W-1:0] cmd_reg; // Command nibbles and cascade bits
  logic wake_en_reg; // Wake-up frame enable
  logic seen_reg; // Wake-frame-seen flag
  logic [NUM_FILTERS-1:0] irq_stat_reg; // Sticky per-filter match
  logic [NUM_FILTERS-1:0] irq_en_reg; // Interrupt enables
  logic [1:0] byte_ptr_reg [IDX_MASK0:IDX_CMD]; // Next byte lane per register

  // Bus holding registers
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Matcher outputs
  logic [NUM_FILTERS-1:0] match_hit;
  logic [IDX_W-1:0] frame_idx_reg;
  logic [IDX_W-1:0] cur_idx;

  // Write commit decode
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_byte_ok;
  logic wr_seq;
  logic [1:0] wr_lane;

  // Read decode
  logic [31:0] rd_data;
  logic rd_ok;
  logic [5:0] rd_idx;

  // Replace one byte lane of a word
  function automatic logic [31:0] put_byte(input logic [31:0] old, input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [31:0] res;
    res = old;
    res[8*lane+:8] = b;
    return res;
  endfunction : put_byte

  // One byte through the reflected CRC-16
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte

  // A write commits once address and data are both held
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign wr_idx = aw_addr_reg[7:2];
  assign wr_byte = w_data_reg[7:0];
  assign wr_byte_ok = w_strb_reg[0];
  // Only registers built from byte sequences carry a lane pointer
  assign wr_seq = (wr_idx >= IDX_MASK0) && (wr_idx <= IDX_CMD);
  assign wr_lane = wr_seq ? byte_ptr_reg[wr_idx] : PTR_RESET;

  // Write address channel; taken in either order with data
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      s_axi_awready_out <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      else if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
      end
      // Ready only while no address or response is held, so one write is under way
      s_axi_awready_out <= !aw_held_reg && !(s_axi_awvalid_in && s_axi_awready_out)
                           && !s_axi_bvalid_out;
    end
  end

  // Write data channel
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= REG_RESET;
      w_strb_reg <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end
    else
    begin
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      else if (wr_fire)
      begin
        w_held_reg <= 1'b0;
      end
      s_axi_wready_out <= !w_held_reg && !(s_axi_wvalid_in && s_axi_wready_out)
                          && !s_axi_bvalid_out;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wr_seq || wr_idx == IDX_WAKE_CS || wr_idx == IDX_IRQ_CLR
                          || wr_idx == IDX_IRQ_EN) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Lane pointers step per byte write and wrap after four
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      for (int i = IDX_MASK0; i <= IDX_CMD; i++)
      begin
        byte_ptr_reg[i] <= PTR_RESET;
      end
    end
    else if (wr_fire && wr_seq && wr_byte_ok)
    begin
      byte_ptr_reg[wr_idx] <= wr_lane + 2'h1;
    end
  end

  // Byte masks, one register per filter
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      for (int k = 0; k < NUM_FILTERS; k++)
      begin
        mask_reg[k] <= REG_RESET;
      end
    end
    else if (wr_fire && wr_byte_ok)
    begin
      for (int k = 0; k < NUM_FILTERS; k++)
      begin
        // Least significant byte lands first
        if (wr_idx == IDX_MASK0 + 6'(k))
        begin
          mask_reg[k] <= put_byte(mask_reg[k], wr_lane, wr_byte);
        end
      end
    end
  end

  // CRC pairs, offsets and last-byte values
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      crc_pair_reg[0] <= REG_RESET;
      crc_pair_reg[1] <= REG_RESET;
      offsets_reg <= REG_RESET;
      last_reg <= REG_RESET;
    end
    else if (wr_fire && wr_byte_ok)
    begin
      case (wr_idx)
        IDX_CRC_LO: crc_pair_reg[0] <= put_byte(crc_pair_reg[0], wr_lane, wr_byte);
        IDX_CRC_HI: crc_pair_reg[1] <= put_byte(crc_pair_reg[1], wr_lane, wr_byte);
        IDX_OFFSETS: offsets_reg <= put_byte(offsets_reg, wr_lane, wr_byte);
        IDX_LAST: last_reg <= put_byte(last_reg, wr_lane, wr_byte);
        default: ; // Other offsets leave these alone
      endcase
    end
  end

  // Command nibbles; lanes above bit 19 are dropped
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      cmd_reg <= CMD_W'(REG_RESET);
    end
    else if (wr_fire && wr_byte_ok && wr_idx == IDX_CMD)
    begin
      cmd_reg <= CMD_W'(put_byte({12'h000, cmd_reg}, wr_lane, wr_byte));
    end
  end

  // Wake control: enable bit and the seen flag, set beats clear
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      wake_en_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      if (wr_fire && wr_byte_ok && wr_idx == IDX_WAKE_CS)
      begin
        wake_en_reg <= wr_byte[WCS_WAKE_EN_BIT];
      end
      if (|match_hit)
      begin
        seen_reg <= 1'b1;
      end
      else if (wr_fire && wr_byte_ok && wr_idx == IDX_WAKE_CS && wr_byte[WCS_FRAME_SEEN_BIT])
      begin
        seen_reg <= 1'b0; // Host writes one to clear
      end
    end
  end

  // Interrupt status, clear and enable
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
    end
    else
    begin
      if (wr_fire && w_strb_reg[0] && wr_idx == IDX_IRQ_EN)
      begin
        irq_en_reg <= w_data_reg[NUM_FILTERS-1:0];
      end
      // A match in the clearing cycle survives the clear
      if (wr_fire && w_strb_reg[0] && wr_idx == IDX_IRQ_CLR)
      begin
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[NUM_FILTERS-1:0]) | match_hit;
      end
      else
      begin
        irq_stat_reg <= irq_stat_reg | match_hit;
      end
    end
  end

  // Event outputs come from flops, one cycle after the status
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      irq_out <= 1'b0;
      wake_frame_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_stat_reg & irq_en_reg);
      wake_frame_out <= seen_reg;
    end
  end

  // Read value decode; full words, reserved bits zero
  assign rd_idx = s_axi_araddr_in[7:2];
  always_comb
  begin
    rd_data = REG_RESET;
    rd_ok = 1'b1;
    case (rd_idx)
      IDX_MASK0: rd_data = mask_reg[0];
      IDX_MASK1: rd_data = mask_reg[1];
      IDX_MASK2: rd_data = mask_reg[2];
      IDX_MASK3: rd_data = mask_reg[3];
      IDX_CRC_LO: rd_data = crc_pair_reg[0];
      IDX_CRC_HI: rd_data = crc_pair_reg[1];
      IDX_OFFSETS: rd_data = offsets_reg;
      IDX_LAST: rd_data = last_reg;
      IDX_CMD: rd_data = {12'h000, cmd_reg};
      IDX_WAKE_CS:
      begin
        rd_data[WCS_WAKE_EN_BIT] = wake_en_reg;
        rd_data[WCS_FRAME_SEEN_BIT] = seen_reg;
      end
      IDX_IRQ_STAT: rd_data[NUM_FILTERS-1:0] = irq_stat_reg;
      IDX_IRQ_CLR: rd_data = REG_RESET; // Write-only, reads zero
      IDX_IRQ_EN: rd_data[NUM_FILTERS-1:0] = irq_en_reg;
      default: rd_ok = 1'b0; // Unmapped
    endcase
  end

  // Read channel; answer in the cycle after the address is taken
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= REG_RESET;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
      end
      s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
    end
  end

  // Frame byte index, shared by all filters; saturates on long frames
  assign cur_idx = rx_beat_in.sof ? '0 : frame_idx_reg;
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      frame_idx_reg <= '0;
    end
    else if (rx_beat_in.valid)
    begin
      frame_idx_reg <= (cur_idx == IDX_MAX) ? IDX_MAX : cur_idx + 11'h001;
    end
  end

  // Per-filter pattern window, CRC and compare
  for (genvar g = 0; g < NUM_FILTERS; g++)
  begin : g_filter
    logic [15:0] crc_reg; // Running CRC of selected bytes
    logic [15:0] crc_cur;
    logic [15:0] crc_upd;
    logic [15:0] crc_want;
    logic [IDX_W:0] base;
    logic [IDX_W:0] rel;
    logic [7:0] last_b;
    logic [CMD_NIBBLE_W-1:0] cmd;
    logic in_win;
    logic take;
    logic qual_ok;

    // Offset counts 16-bit words, so it doubles into bytes
    assign base = {3'h0, offsets_reg[8*g+:8], 1'b0};
    assign rel = {1'b0, cur_idx} - base;
    assign last_b = last_reg[8*g+:8];
    assign crc_want = crc_pair_reg[g/2][16*(g%2)+:16];
    assign cmd = cmd_reg[CMD_NIBBLE_W*g+:CMD_NIBBLE_W];
    assign in_win = ({1'b0, cur_idx} >= base) && (rel < (IDX_W+1)'(PATTERN_LEN));
    // Mask selects bytes; last-byte value cuts the pattern short
    assign take = in_win && mask_reg[g][rel[4:0]]
                  && ({3'h0, rel[4:0]} <= last_b);
    assign crc_cur = rx_beat_in.sof ? CRC_INIT : crc_reg;
    assign crc_upd = take ? crc16_byte(crc_cur, rx_beat_in.data) : crc_cur;
    // Qualifiers only apply when their command bit is set
    assign qual_ok = (!cmd[CMD_DST_BIT] || rx_beat_in.dst_match)
                     && (!cmd[CMD_MCAST_BIT] || rx_beat_in.mcast);
    assign match_hit[g] = rx_beat_in.valid && rx_beat_in.eof && cmd[CMD_EN_BIT]
                          && wake_en_reg && qual_ok && (crc_upd == crc_want);

    // CRC register loads on every valid byte; only selected bytes advance it
    always_ff @(posedge core_clk_in)
    begin
      if (reset_in)
      begin
        crc_reg <= CRC_INIT;
      end
      else if (rx_beat_in.valid)
      begin
        crc_reg <= crc_upd;
      end
    end
  end

endmodule : wff_top
`default_nettype wire

//--- logic/wff_pkg.sv
`default_nettype none
package wff_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MASK0 = 6'h01;
  localparam logic [5:0] IDX_MASK1 = 6'h02;
  localparam logic [5:0] IDX_MASK2 = 6'h03;
  localparam logic [5:0] IDX_MASK3 = 6'h04;
  localparam logic [5:0] IDX_CRC_LO = 6'h05;
  localparam logic [5:0] IDX_CRC_HI = 6'h06;
  localparam logic [5:0] IDX_OFFSETS = 6'h07;
  localparam logic [5:0] IDX_LAST = 6'h08;
  localparam logic [5:0] IDX_CMD = 6'h09;
  localparam logic [5:0] IDX_WAKE_CS = 6'h0a;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h11;
  localparam logic [5:0] IDX_IRQ_EN = 6'h12;

  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // Field positions
  localparam int NUM_FILTERS = 4;
  localparam int PATTERN_LEN = 32;
  localparam int CMD_W = 20;
  localparam int CMD_NIBBLE_W = 4;
  localparam int CMD_EN_BIT = 0;
  localparam int CMD_DST_BIT = 1;
  localparam int CMD_MCAST_BIT = 2;
  localparam int WCS_WAKE_EN_BIT = 1;
  localparam int WCS_FRAME_SEEN_BIT = 5;

  // Mask CRC, reflected form of x^16 + x^15 + x^2 + 1
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;

  // Frame byte index counter
  localparam int IDX_W = 11;
  localparam logic [IDX_W-1:0] IDX_MAX = 11'h7ff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One received byte with its qualifiers
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic dst_match;
    logic mcast;
    logic [7:0] data;
  } wff_rx_beat_s;

endpackage : wff_pkg
`default_nettype wire

//--- verif/wff_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module wff_top_properties
  import wff_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Register bus
  input wire logic s_axi_awready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Frame side
  input wire wff_rx_beat_s rx_beat_in,
  input wire logic wake_frame_out
);
  // One domain, so clock and reset are given once
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_bresp_stands:
  assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out &&
    $stable(s_axi_bresp_out)) else $error("write response dropped early");
  a_rdata_stands:
  assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
    $stable(s_axi_rdata_out)) else $error("read data dropped early");
  a_aw_refused:
  assert property (s_axi_bvalid_out |-> !s_axi_awready_out) else $error("aw open");
  a_ar_refused:
  assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("ar open");
  a_read_answer:
  assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("late read answer");
  a_unmapped_read:
  assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:2] == 6'h00
    |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_read:
  assert property (s_axi_arvalid_in && s_axi_arready_out &&
    s_axi_araddr_in[7:2] inside {[IDX_MASK0:IDX_LAST]} |=> s_axi_rresp_out == RESP_OKAY)
    else $error("config read refused");
  a_wake_cause:
  assert property ($rose(wake_frame_out) |-> $past(rx_beat_in.valid && rx_beat_in.eof, 2))
    else $error("wake without frame end");
endmodule : wff_top_properties
bind wff_top wff_top_properties u_props (.core_clk_in, .reset_in, .s_axi_awready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .rx_beat_in, .wake_frame_out);
`default_nettype wire

//--- verif/wakeup_frame_filter_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, (e), (a)); end end
module wakeup_frame_filter_config_bench
  import wff_pkg::*;
;
  // Table row: index, word sent lowest byte first, word read back
  typedef struct packed {logic [5:0] idx; logic [31:0] wr; logic [31:0] rd;} wff_row_s;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00;
  logic s_axi_awvalid_in = 1'b0;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'h0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic [7:0] s_axi_araddr_in = 8'h00;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  wff_rx_beat_s rx_beat_in = '0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, wake_frame_out, irq_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [15:0] crc; // Expected filter 0 CRC
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  // Command word keeps only its low 20 bits
  wff_row_s rows [9] = '{'{IDX_MASK0, 32'h8000_0001, 32'h8000_0001},
    '{IDX_MASK1, 32'h0102_0304, 32'h0102_0304}, '{IDX_MASK2, 32'hfedc_ba98, 32'hfedc_ba98},
    '{IDX_MASK3, 32'h5555_aaaa, 32'h5555_aaaa}, '{IDX_CRC_LO, 32'hbeef_1234, 32'hbeef_1234},
    '{IDX_CRC_HI, 32'h0f0f_f0f0, 32'h0f0f_f0f0}, '{IDX_OFFSETS, 32'h0403_0201, 32'h0403_0201},
    '{IDX_LAST, 32'hff00_7f80, 32'hff00_7f80}, '{IDX_CMD, 32'hffff_f5a5, 32'h000f_f5a5}};
  initial
  begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  wff_top u_wff_top (.*);
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // Watchdog; the run needs well under a thousand cycles
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      close_out();
    end
  end
  // Synchronous reset seen high at exactly n edges; callers return just after an edge
  task automatic rst(input int n);
    reset_in <= 1'b1;
    repeat (n) @(posedge core_clk_in);
    reset_in <= 1'b0;
  endtask : rst
  // One byte write; each channel is released when taken
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic s,
    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge core_clk_in);
    s_axi_awaddr_in <= {i, 2'b00};
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= {3'h0, s};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (aw || w)
    begin
      @(posedge core_clk_in);
      if (s_axi_awready_out === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wready_out === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    // Ready comes late on purpose, so the response must stand for a cycle
    while (s_axi_bvalid_out !== 1'b1) @(posedge core_clk_in);
    s_axi_bready_in <= 1'b1;
    @(posedge core_clk_in);
    while (s_axi_bvalid_out !== 1'b1) @(posedge core_clk_in);
    s_axi_bready_in <= 1'b0;
    `CHK("bresp", er, s_axi_bresp_out)
  endtask : wr
  // Whole word, lowest byte first
  task automatic wr4(input logic [5:0] i, input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr(i, v[8*k +: 8], 1'b1, RESP_OKAY);
  endtask : wr4
  task automatic rd_chk(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk_in);
    s_axi_araddr_in <= {i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    @(posedge core_clk_in);
    while (s_axi_arready_out !== 1'b1) @(posedge core_clk_in);
    s_axi_arvalid_in <= 1'b0;
    // Late ready, so the read data must stand for a cycle
    @(posedge core_clk_in);
    while (s_axi_rvalid_out !== 1'b1) @(posedge core_clk_in);
    s_axi_rready_in <= 1'b1;
    @(posedge core_clk_in);
    while (s_axi_rvalid_out !== 1'b1) @(posedge core_clk_in);
    s_axi_rready_in <= 1'b0;
    `CHK("rdata", e, s_axi_rdata_out)
    `CHK("rresp", er, s_axi_rresp_out)
  endtask : rd_chk
  // Eight bytes 8'h10 upward, q on both match qualifiers, then time for the flags
  task automatic frame(input logic q);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge core_clk_in);
      rx_beat_in <= '{1'b1, k == 0, k == 7, q, q, 8'h10 + 8'(k)};
    end
    @(posedge core_clk_in);
    rx_beat_in <= '0;
    repeat (3) @(posedge core_clk_in);
  endtask : frame
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    return c;
  endfunction : crc_byte
  initial
  begin
    rst(6);
    foreach (rows[r])
    begin
      wr4(rows[r].idx, rows[r].wr);
      rd_chk(rows[r].idx, rows[r].rd, RESP_OKAY);
    end
    rst(2);
    foreach (rows[r]) rd_chk(rows[r].idx, 32'h0, RESP_OKAY);
    // Pointer restarts; a write without lane 0 strobe stores nothing
    wr(IDX_MASK0, 8'hab, 1'b1, RESP_OKAY);
    wr(IDX_MASK0, 8'hcd, 1'b0, RESP_OKAY);
    wr(IDX_MASK0, 8'hef, 1'b1, RESP_OKAY);
    rd_chk(IDX_MASK0, 32'h0000_efab, RESP_OKAY);
    wr(6'h00, 8'h5a, 1'b1, RESP_SLVERR);
    rd_chk(6'h3f, 32'h0, RESP_SLVERR);
    rd_chk(IDX_IRQ_CLR, 32'h0, RESP_OKAY);
    // Filter 0: skip one word, mask bits 4:0 but last index 3
    rst(2);
    crc = CRC_INIT;
    for (int k = 2; k < 6; k++) crc = crc_byte(crc, 8'h10 + 8'(k));
    wr4(IDX_MASK0, 32'h0000_001f);
    wr4(IDX_CRC_LO, {16'h0, crc});
    wr4(IDX_OFFSETS, 32'h0000_0001);
    wr4(IDX_LAST, 32'h0000_0003);
    wr4(IDX_CMD, 32'h0000_0001);
    wr(IDX_WAKE_CS, 8'h02, 1'b1, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h01, 1'b1, RESP_OKAY);
    `CHK("irq idle", 1'b0, irq_out)
    frame(1'b0);
    `CHK("irq", 1'b1, irq_out)
    `CHK("wake", 1'b1, wake_frame_out)
    rd_chk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    rd_chk(IDX_WAKE_CS, 32'h22, RESP_OKAY);
    // Clear, then mask: status still sets, line stays low
    wr(IDX_IRQ_CLR, 8'h01, 1'b1, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h00, 1'b1, RESP_OKAY);
    wr(IDX_WAKE_CS, 8'h22, 1'b1, RESP_OKAY);
    repeat (2) @(posedge core_clk_in);
    `CHK("irq cleared", 1'b0, irq_out)
    `CHK("wake cleared", 1'b0, wake_frame_out)
    frame(1'b0);
    `CHK("irq masked", 1'b0, irq_out)
    rd_chk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    // Filter disabled: no hit
    wr4(IDX_CMD, 32'h0);
    wr(IDX_IRQ_CLR, 8'h01, 1'b1, RESP_OKAY);
    frame(1'b0);
    rd_chk(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
    // Qualifiers on: only a frame with destination and multicast match hits
    wr4(IDX_CMD, 32'h0000_0007);
    frame(1'b0);
    rd_chk(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
    frame(1'b1);
    rd_chk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    close_out();
  end
endmodule : wakeup_frame_filter_config_bench
`default_nettype wire
